// ---- design/conv_reg_pkg.sv ----
/*
 * Package for the converter bypass and core regulator control registers:
 * register offsets, field positions, reset values, timing constants and
 * the types for the bypass mode, the register request and the power controls.
 * Assumes a single 25 MHz system clock and one asynchronous reset.
 */
package conv_reg_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CONV_MODE_OFFSET = 8'h94;
    localparam logic [7:0] REG_CTRL_OFFSET = 8'hc9;

    // ------------------------------------------------------------------
    // Converter mode fields
    // ------------------------------------------------------------------
    localparam int PASSIVE_DIODE_BIT = 0;
    localparam int BYPASS_SEL_LSB = 1;
    localparam int BYPASS_FLAG_BIT = 3;
    localparam logic PASSIVE_DIODE_RESET = 1'b0;
    localparam logic [1:0] BYPASS_SEL_RESET = 2'h0;

    // ------------------------------------------------------------------
    // Regulator control fields
    // ------------------------------------------------------------------
    localparam int OSC_BIAS_BIT = 4;
    localparam logic OSC_BIAS_RESET = 1'b1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int BIAS_SETTLE_NS = 4000;
    localparam int BIAS_SETTLE_CYCLES_RAW =
        (BIAS_SETTLE_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    localparam int BIAS_SETTLE_CYCLES =
        (BIAS_SETTLE_CYCLES_RAW < 1) ? 1 : BIAS_SETTLE_CYCLES_RAW;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        BYP_OFF = 4'h1,
        BYP_AUTO_OSC_ON = 4'h2,
        BYP_AUTO_OSC_OFF = 4'h4,
        BYP_FORCED = 4'h8
    } bypass_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        bypass_mode_t bypass_mode;
        logic passive_diode_enable;
        logic osc_bias_force;
        logic osc_bias_on;
        logic osc_bias_settled;
        logic core_regulator_enable;
    } power_ctrl_t;

endpackage : conv_reg_pkg

// ---- design/bias_settle_timer.sv ----
/*
 * Settling timer for the precision oscillator bias: counts the settling
 * time after the bias turns on and reports when it is usable.
 * Assumes bias_on_i is synchronous to clk_i.
 */
`timescale 1ns/1ns
module bias_settle_timer
    import conv_reg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bias_on_i,
    output logic settled_o
);

    localparam int CW = $clog2(BIAS_SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(BIAS_SETTLE_CYCLES);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic settled_reg;
    logic settled_next;

    always_comb
    begin
        count_next = count_reg;
        settled_next = settled_reg;
        if (!bias_on_i)
        begin
            count_next = '0;
            settled_next = 1'b0;
        end
        else if (!settled_reg)
        begin
            count_next = count_reg + CW'(1);
            settled_next = (count_next == SETTLE_LAST);
        end
    end

    // Bias is on out of reset, so it counts as settled at once
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            count_reg <= '0;
            settled_reg <= 1'b1;
        end
        else
        begin
            count_reg <= count_next;
            settled_reg <= settled_next;
        end
    end

    assign settled_o = settled_reg;

endmodule : bias_settle_timer

// ---- design/converter_bypass_regulator_ctrl.sv ----
/*
 * Register logic for the converter bypass mode and core regulator control
 * registers, with decoded controls for the analog blocks.
 * Assumes a register port with one-cycle strobes and read data one cycle
 * later; sleep, suspend and live bypass status come from other logic.
 * Those status inputs are asynchronous and pass three-stage synchronisers,
 * so the controls follow a pin change four to five cycles late; software
 * sees the same delay on the bypass flag.
 */
// Strobed register access was decided locally.
// Operation
// RULE1: Converter mode bits 7:4 read zero; writes ignored.
// RULE2: Bit 3 reads live bypass status, one while bypassing.
// RULE3: Bypass select decodes off, auto osc on, auto osc off, forced.
// RULE4: Bit 0 enables passive diode mode; resets to zero.
// RULE5: Regulator bits 6, 5, 0 read zero; software writes zero.
// RULE6: Regulator bits 3:1 read zero; writes have no effect.
// RULE7: Regulator bit 7 reads zero; writes ignored.
// RULE8: Bias bit forces bias on; clear lets it off outside sleep.
// RULE9: Software waits settling time after bias re-enable.
// RULE10: Software clears bias only when oscillator unused.
// RULE11: Core regulator turns off in sleep mode.
// RULE12: Core regulator stays on in suspend mode.
`timescale 1ns/1ns
module converter_bypass_regulator_ctrl
    import conv_reg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input conv_reg_pkg::reg_req_t req_i,
    output logic [7:0] rdata_o,
    input wire logic bypass_status_i,
    input wire logic sleep_i,
    input wire logic suspend_i,
    input wire logic osc_in_use_i,
    output conv_reg_pkg::power_ctrl_t ctrl_o
);
    import conv_reg_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Bypass status and power states come from analog or other domains
    logic [2:0] byp_sync_reg;
    logic [2:0] byp_sync_next;
    logic [2:0] slp_sync_reg;
    logic [2:0] slp_sync_next;
    logic [2:0] sus_sync_reg;
    logic [2:0] sus_sync_next;
    logic [2:0] use_sync_reg;
    logic [2:0] use_sync_next;
    logic bypass_live_reg;
    logic bypass_live_next;
    logic sleep_reg;
    logic sleep_next;
    logic suspend_reg;
    logic suspend_next;
    logic osc_use_reg;
    logic osc_use_next;

    function automatic logic filt(input logic [2:0] s, input logic cur);
        // A change counts once the second and third stages agree
        filt = (s[1] == s[2]) ? s[2] : cur;
    endfunction : filt

    always_comb
    begin
        byp_sync_next = {byp_sync_reg[1:0], bypass_status_i};
        slp_sync_next = {slp_sync_reg[1:0], sleep_i};
        sus_sync_next = {sus_sync_reg[1:0], suspend_i};
        use_sync_next = {use_sync_reg[1:0], osc_in_use_i};
        bypass_live_next = filt(byp_sync_reg, bypass_live_reg);
        sleep_next = filt(slp_sync_reg, sleep_reg);
        suspend_next = filt(sus_sync_reg, suspend_reg);
        osc_use_next = filt(use_sync_reg, osc_use_reg);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            byp_sync_reg <= 3'h0;
            slp_sync_reg <= 3'h0;
            sus_sync_reg <= 3'h0;
            use_sync_reg <= 3'h0;
            bypass_live_reg <= 1'b0;
            sleep_reg <= 1'b0;
            suspend_reg <= 1'b0;
            osc_use_reg <= 1'b0;
        end
        else
        begin
            byp_sync_reg <= byp_sync_next;
            slp_sync_reg <= slp_sync_next;
            sus_sync_reg <= sus_sync_next;
            use_sync_reg <= use_sync_next;
            bypass_live_reg <= bypass_live_next;
            sleep_reg <= sleep_next;
            suspend_reg <= suspend_next;
            osc_use_reg <= osc_use_next;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Shared by all registers so the map is kept in one place
    function automatic logic addr_hit(input logic [7:0] addr,
        input logic [7:0] offset);
        addr_hit = (addr == offset);
    endfunction : addr_hit

    logic conv_wr;
    logic regc_wr;

    assign conv_wr = req_i.wr && addr_hit(req_i.addr, CONV_MODE_OFFSET);
    assign regc_wr = req_i.wr && addr_hit(req_i.addr, REG_CTRL_OFFSET);

    // ------------------------------------------------------------------
    // Converter mode register
    // ------------------------------------------------------------------
    logic passive_diode_reg;
    logic passive_diode_next;
    logic [1:0] bypass_select_reg;
    logic [1:0] bypass_select_next;

    always_comb
    begin
        passive_diode_next = passive_diode_reg;
        bypass_select_next = bypass_select_reg;
        if (conv_wr)
        begin
            // Bits 7:3 are dropped here
            passive_diode_next = req_i.wdata[PASSIVE_DIODE_BIT]; // [RULE4]
            bypass_select_next =
                req_i.wdata[BYPASS_SEL_LSB +: 2]; // [RULE1] [RULE2]
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            passive_diode_reg <= PASSIVE_DIODE_RESET;
            bypass_select_reg <= BYPASS_SEL_RESET;
        end
        else
        begin
            passive_diode_reg <= passive_diode_next;
            bypass_select_reg <= bypass_select_next;
        end
    end

    // ------------------------------------------------------------------
    // Regulator control register
    // ------------------------------------------------------------------
    logic osc_bias_reg;
    logic osc_bias_next;

    always_comb
    begin
        osc_bias_next = osc_bias_reg;
        if (regc_wr)
        begin
            // Only the bias bit is stored; 7, 6:5, 3:1 and 0 are ignored
            osc_bias_next = req_i.wdata[OSC_BIAS_BIT]; // [RULE5] [RULE6] [RULE7]
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            osc_bias_reg <= OSC_BIAS_RESET;
        end
        else
        begin
            osc_bias_reg <= osc_bias_next;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb
    begin
        rdata_next = 8'h00;
        if (req_i.rd)
        begin
            case (req_i.addr)
                CONV_MODE_OFFSET:
                begin
                    rdata_next[BYPASS_FLAG_BIT] = bypass_live_reg; // [RULE2]
                    rdata_next[BYPASS_SEL_LSB +: 2] = bypass_select_reg;
                    rdata_next[PASSIVE_DIODE_BIT] = passive_diode_reg;
                    // Upper nibble left at zero [RULE1]
                end
                REG_CTRL_OFFSET:
                begin
                    // All other bits read zero [RULE5] [RULE6] [RULE7]
                    rdata_next[OSC_BIAS_BIT] = osc_bias_reg;
                end
                default:
                begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

    // ------------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------------
    bypass_mode_t mode_next;
    logic bias_on_next;
    logic reg_en_next;
    logic bias_settled;
    power_ctrl_t ctrl_reg;
    power_ctrl_t ctrl_next;

    // One-hot mode for the analog block; unknown codes fall back to off
    function automatic bypass_mode_t decode_mode(input logic [1:0] sel);
        case (sel)
            2'h0: decode_mode = BYP_OFF;
            2'h1: decode_mode = BYP_AUTO_OSC_ON;
            2'h2: decode_mode = BYP_AUTO_OSC_OFF;
            2'h3: decode_mode = BYP_FORCED;
            default: decode_mode = BYP_OFF;
        endcase
    endfunction : decode_mode

    always_comb
    begin
        mode_next = decode_mode(bypass_select_reg); // [RULE3]
        // Clearing the bias bit only gives permission; the bias is
        // still held while the oscillator is in use, so a careless
        // write cannot starve a running clock.
        bias_on_next = osc_bias_reg || osc_use_reg; // [RULE8] [RULE10]
        if (sleep_reg)
        begin
            bias_on_next = 1'b0;
        end
        // Suspend leaves the regulator running; only sleep stops it
        reg_en_next = 1'b1;
        if (suspend_reg)
        begin
            reg_en_next = 1'b1; // [RULE12]
        end
        if (sleep_reg)
        begin
            reg_en_next = 1'b0; // [RULE11]
        end
        ctrl_next.bypass_mode = mode_next;
        ctrl_next.passive_diode_enable = passive_diode_reg; // [RULE4]
        ctrl_next.osc_bias_force = osc_bias_reg; // [RULE8]
        ctrl_next.osc_bias_on = bias_on_next;
        ctrl_next.osc_bias_settled = bias_settled; // [RULE9]
        ctrl_next.core_regulator_enable = reg_en_next;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_reg.bypass_mode <= BYP_OFF;
            ctrl_reg.passive_diode_enable <= PASSIVE_DIODE_RESET;
            ctrl_reg.osc_bias_force <= OSC_BIAS_RESET;
            ctrl_reg.osc_bias_on <= OSC_BIAS_RESET;
            ctrl_reg.osc_bias_settled <= 1'b1;
            ctrl_reg.core_regulator_enable <= 1'b1;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign ctrl_o = ctrl_reg;

    // ------------------------------------------------------------------
    // Bias settling
    // ------------------------------------------------------------------
    // Flags when software may rely on the oscillator after re-enable
    bias_settle_timer u_settle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bias_on_i(ctrl_reg.osc_bias_on),
        .settled_o(bias_settled)
    );

endmodule : converter_bypass_regulator_ctrl

// ---- tb/conv_reg_assertions.sv ----
/*
 * Checker for the converter bypass and regulator control registers.
 * Sees only the block's ports; one clock, async active-high reset.
 */
`timescale 1ns/1ns
module conv_reg_checker
    import conv_reg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input conv_reg_pkg::reg_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic bypass_status_i,
    input wire logic sleep_i,
    input wire logic suspend_i,
    input wire logic osc_in_use_i,
    input conv_reg_pkg::power_ctrl_t ctrl_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wire rd_conv = req_i.rd && req_i.addr == CONV_MODE_OFFSET;
    wire rd_regc = req_i.rd && req_i.addr == REG_CTRL_OFFSET;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    chk_conv_upper_zero: assert property (
        rd_conv |=> rdata_o[7:4] == 4'h0) else $error("upper bits set");
    chk_bypass_flag_live: assert property (
        ($stable(bypass_status_i))[*8] ##0 rd_conv
        |=> rdata_o[3] == $past(bypass_status_i)) else $error("bad flag");
    chk_regc_reserved_zero: assert property (
        rd_regc |=> rdata_o[6:5] == 2'h0 && !rdata_o[0])
        else $error("reserved bits set");
    chk_regc_unused_zero: assert property (
        rd_regc |=> rdata_o[3:1] == 3'h0) else $error("unused bits set");
    chk_regc_top_zero: assert property (
        rd_regc |=> !rdata_o[7]) else $error("bit 7 set");

    // ------------------------------------------------------------------
    // Power controls; sleep passes a synchroniser, hence eight cycles
    // ------------------------------------------------------------------
    chk_bias_forced_on: assert property (
        (!sleep_i)[*8] ##0 ctrl_o.osc_bias_force
        |-> ctrl_o.osc_bias_on) else $error("bias not on");
    chk_sleep_reg_off: assert property (
        sleep_i[*8] |-> !ctrl_o.core_regulator_enable
        && !ctrl_o.osc_bias_on) else $error("regulator on in sleep");
    chk_suspend_reg_on: assert property (
        (suspend_i && !sleep_i)[*8] |-> ctrl_o.core_regulator_enable)
        else $error("regulator off in suspend");

    cover property (rd_conv ##1 rdata_o[3]);
    cover property (sleep_i[*8]);
    cover property ($rose(ctrl_o.osc_bias_settled));
endmodule : conv_reg_checker

bind converter_bypass_regulator_ctrl conv_reg_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .bypass_status_i(bypass_status_i), .sleep_i(sleep_i),
    .suspend_i(suspend_i), .osc_in_use_i(osc_in_use_i), .ctrl_o(ctrl_o));

// ---- tb/testbench.sv ----
/*
 * Self-checking bench for the converter and regulator register block.
 * Drives the register port and power-state levels directly.
 */
`timescale 1ns/1ns
module testbench;
    import conv_reg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    reg_req_t req_i = '0;
    logic [7:0] rdata_o;
    logic bypass_status_i = 1'b0;
    logic sleep_i = 1'b0;
    logic suspend_i = 1'b0;
    logic osc_in_use_i = 1'b0;
    power_ctrl_t ctrl_o;
    int error_cnt = 0;
    int checked = 0;

    always #20 clk_i = ~clk_i;

    converter_bypass_regulator_ctrl dut (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
        .bypass_status_i(bypass_status_i), .sleep_i(sleep_i),
        .suspend_i(suspend_i), .osc_in_use_i(osc_in_use_i),
        .ctrl_o(ctrl_o));

    // ------------------------------------------------------------------
    // Bus and compare tasks; each starts just after a rising edge
    // ------------------------------------------------------------------
    task automatic cmp(input string nm, input logic [7:0] exp,
        input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : cmp

    task automatic wrap_up;
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // Strobe is left up so a following access may come with no gap
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        req_i <= {a, d, 2'b10};
        @(posedge clk_i);
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp,
        input string nm);
        req_i <= {a, 8'h00, 2'b01};
        @(posedge clk_i);
        req_i <= '0;
        #1 cmp(nm, exp, rdata_o);
        @(posedge clk_i);
    endtask : bus_rd

    task automatic idle(input int n);
        req_i <= '0;
        repeat (n) @(posedge clk_i);
    endtask : idle

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        cmp("mode", {4'h0, BYP_OFF}, {4'h0, ctrl_o.bypass_mode});
        cmp("diode", 8'h00, {7'h0, ctrl_o.passive_diode_enable});
        cmp("force", 8'h01, {7'h0, ctrl_o.osc_bias_force});
        cmp("settle", 8'h01, {7'h0, ctrl_o.osc_bias_settled});
        cmp("reg_en", 8'h01, {7'h0, ctrl_o.core_regulator_enable});
        bus_rd(CONV_MODE_OFFSET, 8'h00, "conv");
        bus_rd(REG_CTRL_OFFSET, 8'h10, "regc");
    endtask : t_reset

    task automatic t_conv;
        logic [3:0] hot;
        for (int i = 0; i < 8; i++)
        begin
            hot = 4'h1 << i[2:1];
            bus_wr(CONV_MODE_OFFSET, 8'hf8 | i[7:0]);
            bus_rd(CONV_MODE_OFFSET, i[7:0], "conv");
            cmp("mode", {4'h0, hot}, {4'h0, ctrl_o.bypass_mode});
            cmp("diode", {7'h0, i[0]}, {7'h0, ctrl_o.passive_diode_enable});
        end
        bypass_status_i <= 1'b1;
        idle(8);
        bus_wr(CONV_MODE_OFFSET, 8'h00);
        bus_rd(CONV_MODE_OFFSET, 8'h08, "flag");
        bypass_status_i <= 1'b0;
        idle(8);
        bus_rd(CONV_MODE_OFFSET, 8'h00, "flag");
    endtask : t_conv

    task automatic t_regc;
        int n;
        bus_wr(8'h00, 8'h55);
        bus_rd(8'h00, 8'h00, "unmapped");
        // Reserved bits 6:5 and 0 are always written as zero
        bus_wr(REG_CTRL_OFFSET, 8'h9e);
        bus_rd(REG_CTRL_OFFSET, 8'h10, "regc");
        bus_wr(REG_CTRL_OFFSET, 8'h8e);
        bus_rd(REG_CTRL_OFFSET, 8'h00, "regc");
        idle(8);
        cmp("force", 8'h00, {7'h0, ctrl_o.osc_bias_force});
        cmp("bias_on", 8'h00, {7'h0, ctrl_o.osc_bias_on});
        osc_in_use_i <= 1'b1;
        idle(8);
        cmp("bias_on", 8'h01, {7'h0, ctrl_o.osc_bias_on});
        osc_in_use_i <= 1'b0;
        idle(8);
        bus_wr(REG_CTRL_OFFSET, 8'h10);
        idle(2);
        cmp("bias_on", 8'h01, {7'h0, ctrl_o.osc_bias_on});
        cmp("force", 8'h01, {7'h0, ctrl_o.osc_bias_force});
        // Settling is 4 us, so 100 cycles at 25 MHz
        n = 0;
        while (ctrl_o.osc_bias_settled !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        // A hang counts here and the run goes on to the verdict
        if (n == 200)
        begin
            error_cnt++;
        end
        cmp("settle", 8'h01, {7'h0, n >= 90 && n <= 110});
    endtask : t_regc

    task automatic t_power;
        suspend_i <= 1'b1;
        idle(10);
        cmp("reg_en", 8'h01, {7'h0, ctrl_o.core_regulator_enable});
        sleep_i <= 1'b1;
        idle(10);
        cmp("reg_en", 8'h00, {7'h0, ctrl_o.core_regulator_enable});
        cmp("bias_on", 8'h00, {7'h0, ctrl_o.osc_bias_on});
        sleep_i <= 1'b0;
        suspend_i <= 1'b0;
        idle(10);
        cmp("reg_en", 8'h01, {7'h0, ctrl_o.core_regulator_enable});
        cmp("bias_on", 8'h01, {7'h0, ctrl_o.osc_bias_on});
    endtask : t_power

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_conv();
        t_regc();
        t_power();
        wrap_up();
    end
endmodule : testbench
